// ===== rtl/cpe_engine.sv
// Channel packet engine: virtual channels multiplexed over one link.
// Assumes link tokens and processor requests on ref_clk; ce gates all.
`timescale 1ns/1ns
`default_nettype none
`include "cpe_regs.svh"
module cpe_engine import cpe_pkg::*; #(
    parameter int N = `CPE_NUM_CH,
    parameter int LW = `CPE_LEN_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic out_req,
    input wire logic [$clog2(N)-1:0] out_ch,
    input wire logic [LW-1:0] out_len,
    output logic out_done,
    output logic [$clog2(N)-1:0] out_done_ch,
    output logic src_req,
    output logic [$clog2(N)-1:0] src_ch,
    input wire logic [7:0] src_byte,
    input wire logic in_req,
    input wire logic [$clog2(N)-1:0] in_ch,
    input wire logic [LW-1:0] in_len,
    output logic in_done,
    output logic [$clog2(N)-1:0] in_done_ch,
    output logic [LW-1:0] in_done_cnt,
    output logic dst_valid,
    output logic [$clog2(N)-1:0] dst_ch,
    output logic [7:0] dst_byte,
    input wire logic [$clog2(N)-1:0] cnt_ch,
    output logic [LW-1:0] cnt_val,
    output logic tx_valid,
    input wire logic tx_ready,
    output cpe_link_t tx_tok,
    input wire logic rx_valid,
    input wire cpe_link_t rx_tok,
    output logic err,
    output cpe_err_t err_kind
);
    localparam int IW = $clog2(N);
    localparam logic [5:0] MAXD = `CPE_MAX_DATA;
    if (N < 2 || N > 256 || LW < 7) begin : g_bad
        $error("cpe_engine: channel count or length width unsupported");
    end

    typedef struct packed {
        cpe_tx_st_t tx_st;
        logic [IW-1:0] tx_ch;
        logic tx_ack, tx_last;
        logic [5:0] tx_n, tx_len;
        logic [IW-1:0] rptr;
        logic tx_valid;
        cpe_link_t tx_tok;
        logic [N-1:0] out_act, out_fin, wait_ack, ack_pend;
        logic [N-1:0] in_act, in_ovr, buf_full, buf_last;
        logic [N-1:0][LW-1:0] out_rem, in_rem, in_cnt;
        logic [N-1:0][5:0] buf_len;
        cpe_rx_st_t rx_st;
        logic [IW-1:0] rx_ch;
        logic [5:0] rx_n;
        logic rx_bad, rx_dl;
        logic cp_act;
        logic [IW-1:0] cp_ch;
        logic [5:0] cp_idx;
        logic dst_valid;
        logic [IW-1:0] dst_ch;
        logic [7:0] dst_byte;
        logic out_done, in_done;
        logic [IW-1:0] out_done_ch, in_done_ch;
        logic [LW-1:0] in_done_cnt, cnt_val;
        logic err;
        cpe_err_t err_kind;
    } cpe_state_t;

    cpe_state_t s_ff, nxt_s;
    logic ack_any, dat_any, cp_any, tx_load, dv, rx_fin, fin_v, buf_wr, src_pull;
    logic [IW-1:0] ack_idx, dat_idx, cp_sel, pch, dch, fin_ch;
    logic [7:0] dbyte, buf_rd;

    // Acknowledges first: a stalled acknowledge would stall the far sender
    cpe_pick #(.N(N), .IW(IW)) u_ack_pick (
        .req(s_ff.ack_pend),
        .after(s_ff.rptr),
        .any(ack_any),
        .idx(ack_idx)
    );
    cpe_pick #(.N(N), .IW(IW)) u_dat_pick (
        .req(s_ff.out_act & ~s_ff.wait_ack & ~s_ff.out_fin),
        .after(s_ff.rptr),
        .any(dat_any),
        .idx(dat_idx)
    );
    cpe_pick #(.N(N), .IW(IW)) u_cp_pick (
        .req(s_ff.in_act & s_ff.buf_full),
        .after(s_ff.cp_ch),
        .any(cp_any),
        .idx(cp_sel)
    );
    cpe_pbuf #(.N(N), .IW(IW)) u_pbuf (
        .ref_clk(ref_clk),
        .ce(ce),
        .wr_en(buf_wr),
        .wr_ch(s_ff.rx_ch),
        .wr_idx(s_ff.rx_n[4:0]),
        .wr_byte(rx_tok.byte_v),
        .rd_ch(s_ff.cp_ch),
        .rd_idx(s_ff.cp_idx[4:0]),
        .rd_byte(buf_rd)
    );

    assign tx_load = !s_ff.tx_valid || tx_ready;

    always_comb begin
        nxt_s = s_ff;
        dv = 1'b0;
        dch = s_ff.rx_ch;
        dbyte = rx_tok.byte_v;
        rx_fin = 1'b0;
        fin_v = 1'b0;
        fin_ch = s_ff.rx_ch;
        buf_wr = 1'b0;
        src_pull = 1'b0;
        pch = ack_any ? ack_idx : dat_idx;
        nxt_s.dst_valid = 1'b0;
        nxt_s.out_done = 1'b0;
        nxt_s.in_done = 1'b0;
        nxt_s.err = 1'b0;
        if (tx_load) begin
            nxt_s.tx_valid = 1'b0;
        end
        if (out_req && !s_ff.out_act[out_ch]) begin
            nxt_s.out_act[out_ch] = 1'b1;
            nxt_s.out_fin[out_ch] = 1'b0;
            nxt_s.out_rem[out_ch] = out_len;
        end
        if (in_req && !s_ff.in_act[in_ch]) begin
            nxt_s.in_act[in_ch] = 1'b1;
            nxt_s.in_rem[in_ch] = in_len;
            nxt_s.in_cnt[in_ch] = '0;
            nxt_s.in_ovr[in_ch] = 1'b0;
        end

        case (s_ff.tx_st)
            CPE_TX_IDLE: begin
                if (tx_load && (ack_any || dat_any)) begin
                    nxt_s.tx_ch = pch;
                    nxt_s.rptr = pch;
                    nxt_s.tx_ack = ack_any;
                    nxt_s.tx_n = '0;
                    nxt_s.tx_last = s_ff.out_rem[pch] <= LW'(MAXD);
                    nxt_s.tx_len = nxt_s.tx_last ? s_ff.out_rem[pch][5:0] : MAXD;
                    if (ack_any) begin
                        nxt_s.ack_pend[pch] = 1'b0;
                    end
                    // Destination only; the pair identifies us
                    nxt_s.tx_valid = 1'b1;
                    nxt_s.tx_tok = '{kind: CPE_TK_HEADER, byte_v: 8'(pch)};
                    nxt_s.tx_st = (ack_any || nxt_s.tx_len == '0) ? CPE_TX_END : CPE_TX_DATA;
                end
            end
            CPE_TX_DATA: begin
                if (tx_load) begin
                    src_pull = 1'b1;
                    nxt_s.tx_valid = 1'b1;
                    nxt_s.tx_tok = '{kind: CPE_TK_DATA, byte_v: src_byte};
                    nxt_s.out_rem[s_ff.tx_ch] = s_ff.out_rem[s_ff.tx_ch] - LW'(1);
                    nxt_s.tx_n = s_ff.tx_n + 6'h01;
                    if (nxt_s.tx_n == s_ff.tx_len) begin
                        nxt_s.tx_st = CPE_TX_END;
                    end
                end
            end
            CPE_TX_END: begin
                if (tx_load) begin
                    nxt_s.tx_valid = 1'b1;
                    nxt_s.tx_tok.byte_v = 8'h00;
                    nxt_s.tx_tok.kind = (!s_ff.tx_ack && s_ff.tx_last) ?
                        CPE_TK_MESSAGE_END : CPE_TK_PACKET_END;
                    if (!s_ff.tx_ack) begin
                        nxt_s.wait_ack[s_ff.tx_ch] = 1'b1;
                        nxt_s.out_fin[s_ff.tx_ch] = s_ff.tx_last;
                    end
                    nxt_s.tx_st = CPE_TX_IDLE;
                end
            end
            default: nxt_s.tx_st = CPE_TX_IDLE;
        endcase

        if (rx_valid) begin
            case (s_ff.rx_st)
                CPE_RX_HEAD: begin
                    nxt_s.rx_n = '0;
                    if (rx_tok.kind == CPE_TK_HEADER) begin
                        nxt_s.rx_ch = rx_tok.byte_v[IW-1:0];
                        nxt_s.rx_bad = int'(rx_tok.byte_v) >= N;
                        nxt_s.err = nxt_s.rx_bad;
                        nxt_s.rx_dl = s_ff.in_act[nxt_s.rx_ch] && !s_ff.buf_full[nxt_s.rx_ch];
                        nxt_s.rx_st = CPE_RX_BODY;
                    end else begin
                        nxt_s.err = 1'b1;
                    end
                    nxt_s.err_kind = CPE_ERR_HEADER;
                end
                CPE_RX_BODY: begin
                    case (rx_tok.kind)
                        CPE_TK_DATA: begin
                            if (!s_ff.rx_bad && s_ff.rx_n == MAXD) begin
                                nxt_s.err = 1'b1;
                                nxt_s.err_kind = CPE_ERR_OVERSIZE;
                                nxt_s.rx_bad = 1'b1;
                            end else if (!s_ff.rx_bad) begin
                                nxt_s.rx_n = s_ff.rx_n + 6'h01;
                                dv = s_ff.rx_dl;
                                buf_wr = !s_ff.rx_dl;
                            end
                        end
                        CPE_TK_PACKET_END, CPE_TK_MESSAGE_END: begin
                            nxt_s.rx_st = CPE_RX_HEAD;
                            if (s_ff.rx_bad) begin
                                nxt_s.rx_bad = 1'b0;
                            end else if (s_ff.rx_n == '0 && rx_tok.kind == CPE_TK_PACKET_END) begin
                                nxt_s.wait_ack[s_ff.rx_ch] = 1'b0;
                                if (s_ff.out_fin[s_ff.rx_ch]) begin
                                    nxt_s.out_act[s_ff.rx_ch] = 1'b0;
                                    nxt_s.out_fin[s_ff.rx_ch] = 1'b0;
                                    nxt_s.out_done = 1'b1;
                                    nxt_s.out_done_ch = s_ff.rx_ch;
                                end
                            end else if (rx_tok.kind == CPE_TK_PACKET_END && s_ff.rx_n != MAXD) begin
                                nxt_s.err = 1'b1;
                                nxt_s.err_kind = CPE_ERR_SHORT;
                            end else if (s_ff.rx_dl) begin
                                nxt_s.ack_pend[s_ff.rx_ch] = 1'b1;
                                rx_fin = rx_tok.kind == CPE_TK_MESSAGE_END;
                            end else begin
                                nxt_s.buf_full[s_ff.rx_ch] = 1'b1;
                                nxt_s.buf_len[s_ff.rx_ch] = s_ff.rx_n;
                                nxt_s.buf_last[s_ff.rx_ch] = rx_tok.kind == CPE_TK_MESSAGE_END;
                            end
                        end
                        default: begin
                            nxt_s.err = !s_ff.rx_bad;
                            nxt_s.err_kind = CPE_ERR_HEADER;
                            nxt_s.rx_bad = 1'b1;
                        end
                    endcase
                end
                default: nxt_s.rx_st = CPE_RX_HEAD;
            endcase
        end

        // Copy steals only cycles the link leaves free, since rx cannot stall
        if (!s_ff.cp_act) begin
            if (cp_any) begin
                nxt_s.cp_act = 1'b1;
                nxt_s.cp_ch = cp_sel;
                nxt_s.cp_idx = '0;
            end
        end else if (s_ff.cp_idx == s_ff.buf_len[s_ff.cp_ch]) begin
            if (!rx_fin) begin
                nxt_s.buf_full[s_ff.cp_ch] = 1'b0;
                nxt_s.ack_pend[s_ff.cp_ch] = 1'b1;
                nxt_s.cp_act = 1'b0;
                fin_v = s_ff.buf_last[s_ff.cp_ch];
                fin_ch = s_ff.cp_ch;
            end
        end else if (!dv) begin
            dv = 1'b1;
            dch = s_ff.cp_ch;
            dbyte = buf_rd;
            nxt_s.cp_idx = s_ff.cp_idx + 6'h01;
        end
        if (rx_fin) begin
            fin_v = 1'b1;
        end

        if (dv) begin
            if (s_ff.in_rem[dch] == '0) begin
                nxt_s.in_ovr[dch] = 1'b1;
            end else begin
                nxt_s.dst_valid = 1'b1;
                nxt_s.dst_ch = dch;
                nxt_s.dst_byte = dbyte;
                nxt_s.in_rem[dch] = s_ff.in_rem[dch] - LW'(1);
                nxt_s.in_cnt[dch] = s_ff.in_cnt[dch] + LW'(1);
            end
        end
        if (fin_v) begin
            nxt_s.in_act[fin_ch] = 1'b0;
            nxt_s.in_done = 1'b1;
            nxt_s.in_done_ch = fin_ch;
            nxt_s.in_done_cnt = s_ff.in_ovr[fin_ch] ? '1 : s_ff.in_cnt[fin_ch];
        end
        nxt_s.cnt_val = nxt_s.in_ovr[cnt_ch] ? '1 : nxt_s.in_cnt[cnt_ch];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_ff <= '0;
        end else if (ce) begin
            s_ff <= nxt_s;
        end
    end

    // Offer tokens and pull bytes only while state can advance
    assign tx_valid = s_ff.tx_valid && ce;
    assign tx_tok = s_ff.tx_tok;
    assign src_req = src_pull && ce;
    assign src_ch = s_ff.tx_ch;
    assign out_done = s_ff.out_done;
    assign out_done_ch = s_ff.out_done_ch;
    assign in_done = s_ff.in_done;
    assign in_done_ch = s_ff.in_done_ch;
    assign in_done_cnt = s_ff.in_done_cnt;
    assign dst_valid = s_ff.dst_valid;
    assign dst_ch = s_ff.dst_ch;
    assign dst_byte = s_ff.dst_byte;
    assign cnt_val = s_ff.cnt_val;
    assign err = s_ff.err;
    assign err_kind = s_ff.err_kind;

    logic tx_take;
    logic [6:0] dcnt_ff;
    assign tx_take = tx_valid && tx_ready;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dcnt_ff <= '0;
        end else if (tx_take) begin
            dcnt_ff <= (tx_tok.kind == CPE_TK_DATA) ? dcnt_ff + 7'h01 : '0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence seq_tx_end;
        tx_take && (tx_tok.kind == CPE_TK_PACKET_END || tx_tok.kind == CPE_TK_MESSAGE_END);
    endsequence
    sequence seq_rx_end;
        ce && rx_valid && s_ff.rx_st == CPE_RX_BODY && !s_ff.rx_bad;
    endsequence
    chk_pkt_max_len: assert property (tx_take && tx_tok.kind == CPE_TK_DATA |-> dcnt_ff < 7'h20)
        else $error("more than 32 data bytes in a packet");
    // Checked at the taking edge: a new packet may start right after it
    chk_end_to_idle: assert property (seq_tx_end |-> s_ff.tx_st == CPE_TX_IDLE)
        else $error("end token did not close the packet");
    chk_ack_empty: assert property (tx_take && tx_tok.kind == CPE_TK_HEADER && s_ff.tx_ack
        |-> s_ff.tx_st == CPE_TX_END)
        else $error("acknowledge packet carries data");
    chk_wait_set: assert property (seq_tx_end and (!s_ff.tx_ack)
        |=> s_ff.wait_ack[$past(s_ff.tx_ch)])
        else $error("data packet sent without awaiting acknowledge");
    chk_src_gate: assert property (src_req |-> s_ff.tx_st == CPE_TX_DATA && !s_ff.wait_ack[src_ch])
        else $error("data pulled while acknowledge outstanding");
    chk_mend_last: assert property (tx_take && tx_tok.kind == CPE_TK_MESSAGE_END
        |-> s_ff.tx_last && !s_ff.tx_ack && s_ff.tx_n == s_ff.tx_len)
        else $error("message end on a non-final packet");
    chk_short_err: assert property (seq_rx_end ##0 (rx_tok.kind == CPE_TK_PACKET_END
        && s_ff.rx_n != 6'h00 && s_ff.rx_n != MAXD) |=> err && err_kind == CPE_ERR_SHORT)
        else $error("short middle packet not flagged");
    chk_ack_clear: assert property (seq_rx_end ##0 (rx_tok.kind == CPE_TK_PACKET_END
        && s_ff.rx_n == 6'h00) |=> !s_ff.wait_ack[$past(s_ff.rx_ch)])
        else $error("acknowledge did not release the channel");
    chk_ovr_mark: assert property (seq_rx_end ##0 (rx_tok.kind == CPE_TK_MESSAGE_END
        && s_ff.rx_dl && s_ff.in_ovr[s_ff.rx_ch]) |=> in_done && in_done_cnt == '1)
        else $error("overrun not reported as minus one");
    chk_copy_ack: assert property (ce && s_ff.cp_act && !rx_fin
        && s_ff.cp_idx == s_ff.buf_len[s_ff.cp_ch] |=> s_ff.ack_pend[$past(s_ff.cp_ch)])
        else $error("buffered packet copied without acknowledge");
endmodule : cpe_engine
`default_nettype wire

// ===== rtl/cpe_pbuf.sv
// Early packet store: one packet of data bytes per virtual link.
// Assumes a write and a read of the same byte never coincide.
`timescale 1ns/1ns
`default_nettype none
`include "cpe_regs.svh"
module cpe_pbuf import cpe_pkg::*; #(
    parameter int N = 4,
    parameter int IW = 2,
    parameter int DEPTH = `CPE_BUF_DEPTH,
    parameter int AW = `CPE_BUF_AW
) (
    input wire logic ref_clk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [IW-1:0] wr_ch,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [7:0] wr_byte,
    input wire logic [IW-1:0] rd_ch,
    input wire logic [AW-1:0] rd_idx,
    output logic [7:0] rd_byte
);
    if (DEPTH != (1 << AW) || (1 << IW) < N) begin : g_bad
        $error("cpe_pbuf: depth or index width mismatch");
    end
    // Not reset: a byte is read only after a packet has been written over it
    logic [7:0] mem_ff [(1 << IW) * DEPTH];
    always_ff @(posedge ref_clk) begin
        if (ce && wr_en) begin
            mem_ff[{wr_ch, wr_idx}] <= wr_byte;
        end
    end
    assign rd_byte = mem_ff[{rd_ch, rd_idx}];
endmodule : cpe_pbuf
`default_nettype wire

// ===== rtl/cpe_pick.sv
// Round-robin picker: lowest request index following the last grant.
// Assumes purely combinational use on one clock.
`timescale 1ns/1ns
`default_nettype none
module cpe_pick import cpe_pkg::*; #(
    parameter int N = 4,
    parameter int IW = 2
) (
    input wire logic [N-1:0] req,
    input wire logic [IW-1:0] after,
    output logic any,
    output logic [IW-1:0] idx
);
    if (N < 2 || (1 << IW) < N) begin : g_bad
        $error("cpe_pick: index too narrow");
    end
    always_comb begin
        any = 1'b0;
        idx = '0;
        // Walk backwards so the nearest request after the last grant wins
        for (int k = N; k >= 1; k--) begin
            int j;
            j = (int'(after) + k) % N;
            if (req[j]) begin
                any = 1'b1;
                idx = IW'(j);
            end
        end
    end
endmodule : cpe_pick
`default_nettype wire

// ===== rtl/cpe_pkg.sv
// Types shared by the channel packet engine files.
// Assumes nothing beyond a SystemVerilog tool.
package cpe_pkg;
    typedef enum logic [1:0] {
        CPE_TK_HEADER,
        CPE_TK_DATA,
        CPE_TK_PACKET_END,
        CPE_TK_MESSAGE_END
    } cpe_tok_t;
    typedef struct packed {
        cpe_tok_t kind;
        logic [7:0] byte_v;
    } cpe_link_t;
    typedef enum logic [1:0] {CPE_ERR_HEADER, CPE_ERR_SHORT, CPE_ERR_OVERSIZE} cpe_err_t;
    typedef enum logic [1:0] {CPE_TX_IDLE, CPE_TX_DATA, CPE_TX_END} cpe_tx_st_t;
    typedef enum logic {CPE_RX_HEAD, CPE_RX_BODY} cpe_rx_st_t;
endpackage : cpe_pkg

// ===== rtl/cpe_regs.svh
// Constants of the channel packet engine: packet limits and defaults.
// Assumes inclusion by its bare name from any file that needs them.
`ifndef CPE_REGS_SVH
`define CPE_REGS_SVH
// Data bytes carried by a full packet
`define CPE_MAX_DATA 6'h20
// Default number of virtual links
`define CPE_NUM_CH 4
// Default width of length and count words
`define CPE_LEN_W 16
// Depth of one packet buffer, and its index width
`define CPE_BUF_DEPTH 32
`define CPE_BUF_AW 5
`endif

// ===== tb/cpe_far.sv
// Far-side engine model: takes link tokens, plays queued tokens, acks data.
// Assumes the bench fills sq with whole packets; hold pauses all sending.
`timescale 1ns/1ns
`default_nettype none
module cpe_far import cpe_pkg::*; (
    input wire logic ref_clk,
    input wire logic hold,
    input wire logic slow,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire cpe_link_t tx_tok,
    output logic rx_valid,
    output cpe_link_t rx_tok
);
    cpe_link_t sq[$];
    cpe_link_t got[$];
    logic [7:0] hd = 8'h00;
    int nd = 0;
    int cyc = 0;
    initial tx_ready = 1'b0;
    initial rx_valid = 1'b0;
    initial rx_tok = '0;
    always @(negedge ref_clk) begin
        cyc <= cyc + 1;
        tx_ready <= !slow || (cyc % 3 == 0);
        if (sq.size() > 0 && !hold) begin
            rx_valid <= 1'b1;
            rx_tok <= sq.pop_front();
        end else begin
            rx_valid <= 1'b0;
            // Idle line keeps moving so a stale token is never mistaken for news
            rx_tok <= cpe_link_t'(~rx_tok);
        end
    end
    always @(posedge ref_clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_tok);
            if (tx_tok.kind == CPE_TK_HEADER) hd = tx_tok.byte_v;
            nd = (tx_tok.kind == CPE_TK_HEADER) ? 0 : nd + int'(tx_tok.kind == CPE_TK_DATA);
            if (tx_tok.kind == CPE_TK_MESSAGE_END || (tx_tok.kind == CPE_TK_PACKET_END && nd > 0)) begin
                sq.push_back('{CPE_TK_HEADER, hd});
                sq.push_back('{CPE_TK_PACKET_END, 8'h00});
            end
        end
    end
endmodule : cpe_far
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench of the channel packet engine with a far-side model.
// Assumes cpe_far on the link; ce drops once for a short freeze.
`timescale 1ns/1ns
`default_nettype none
module testbench import cpe_pkg::*;;
    logic ref_clk, rst, ce, out_req, in_req, src_req, out_done, in_done, dst_valid;
    logic tx_valid, tx_ready, rx_valid, err, hold, slow;
    logic [1:0] out_ch, out_done_ch, src_ch, in_ch, in_done_ch, dst_ch, cnt_ch, dch, och, dsc, ssc;
    logic [15:0] out_len, in_len, in_done_cnt, cnt_val, dcnt;
    logic [7:0] src_byte, dst_byte, sb[64], dq[$], eq[$];
    cpe_link_t tx_tok, rx_tok, xq[$];
    cpe_err_t err_kind, ek;
    int errors = 0, num_checks = 0, ev = 0, si = 0, seed = 32'h31ea;
    int cc[4] = '{2, 3, 0, 1}, cn[4] = '{5, 4, 3, 32}, cl[4] = '{10, 4, 2, 32};
    cpe_engine i_cpe_engine (.ref_clk, .rst, .ce, .out_req, .out_ch, .out_len, .out_done,
        .out_done_ch, .src_req, .src_ch, .src_byte, .in_req, .in_ch, .in_len, .in_done,
        .in_done_ch, .in_done_cnt, .dst_valid, .dst_ch, .dst_byte, .cnt_ch, .cnt_val,
        .tx_valid, .tx_ready, .tx_tok, .rx_valid, .rx_tok, .err, .err_kind);
    cpe_far far (.ref_clk, .hold, .slow, .tx_valid, .tx_ready, .tx_tok, .rx_valid, .rx_tok);
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (src_req) si <= si + 1;
        if (dst_valid) dq.push_back(dst_byte);
        if (dst_valid) dsc <= dst_ch;
        if (src_req) ssc <= src_ch;
        if (in_done) dcnt <= in_done_cnt;
        if (in_done) dch <= in_done_ch;
        if (out_done) och <= out_done_ch;
        if (err) ek <= err_kind;
        if (in_done || out_done || err) ev <= ev + 1;
    end
    always @(negedge ref_clk) src_byte <= sb[si];
    function automatic logic [15:0] exp_cnt(input int n, input int len);
        return (n > len) ? 16'hffff : 16'(n);
    endfunction : exp_cnt
    task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk_v
    task automatic chk_t(input string nm);
        int bad;
        bad = (far.got.size() == xq.size()) ? -1 : 0;
        foreach (xq[i]) if (bad < 0 && far.got[i] !== xq[i]) bad = i;
        num_checks++;
        if (bad >= 0) begin
            errors++;
            $display("[ERR] %s token %0d exp %h got %h", nm, bad, xq[bad], far.got[bad]);
        end
    endtask : chk_t
    task automatic tk(input cpe_tok_t k, input logic [7:0] b);
        xq.push_back('{k, b});
    endtask : tk
    task automatic rx(input logic [7:0] ch, input int n, input cpe_tok_t e);
        logic [7:0] b;
        far.sq.push_back('{CPE_TK_HEADER, ch});
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            eq.push_back(b);
            far.sq.push_back('{CPE_TK_DATA, b});
        end
        far.sq.push_back('{e, 8'h00});
    endtask : rx
    task automatic req(input logic o, input logic [1:0] c, input logic [15:0] l);
        @(negedge ref_clk);
        {out_req, in_req} = {o, !o};
        {out_ch, out_len, in_ch, in_len} = {c, l, c, l};
        @(negedge ref_clk);
        {out_req, in_req} = 2'h0;
    endtask : req
    task automatic till(input int t);
        for (int j = 0; j < 3000 && ev < t; j++) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : till
    task automatic stop_test();
        if (errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    // Whole run needs under a thousand cycles; this bound is 50000 cycles
    initial begin
        #1000000;
        errors++;
        stop_test();
    end
    initial begin
        {rst, ce, out_req, in_req, hold, slow} = 6'h33;
        {out_ch, out_len, in_ch, in_len, cnt_ch, src_byte} = '0;
        foreach (sb[i]) sb[i] = 8'($random(seed));
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        req(1'b1, 2'h1, 16'h28);
        repeat (20) @(negedge ref_clk);
        ce = 1'b0;
        repeat (5) @(negedge ref_clk);
        chk_v("frozen", 16'h0, 16'({tx_valid, src_req}));
        ce = 1'b1;
        repeat (175) @(negedge ref_clk);
        tk(CPE_TK_HEADER, 8'h01);
        for (int i = 0; i < 32; i++) tk(CPE_TK_DATA, sb[i]);
        tk(CPE_TK_PACKET_END, 8'h00);
        chk_t("first packet");
        chk_v("early done", 16'h0, 16'(ev));
        chk_v("src ch", 16'h1, 16'(ssc));
        hold = 1'b0;
        till(ev + 1);
        tk(CPE_TK_HEADER, 8'h01);
        for (int i = 32; i < 40; i++) tk(CPE_TK_DATA, sb[i]);
        tk(CPE_TK_MESSAGE_END, 8'h00);
        chk_t("last packet");
        chk_v("out ch", 16'h1, 16'(och));
        slow = 1'b0;
        // Direct, buffered, overrun and full-packet inputs in turn
        for (int t = 0; t < 4; t++) begin
            dq.delete();
            eq.delete();
            xq.delete();
            far.got.delete();
            if (t != 1) req(1'b0, 2'(cc[t]), 16'(cl[t]));
            rx(8'(cc[t]), cn[t], CPE_TK_MESSAGE_END);
            if (t == 1) begin
                repeat (60) @(negedge ref_clk);
                chk_v("held bytes", 16'h0, 16'(dq.size()));
                chk_v("early ack", 16'h0, 16'(far.got.size()));
                req(1'b0, 2'(cc[t]), 16'(cl[t]));
            end
            till(ev + 1);
            for (int i = 0; i < cn[t] && i < cl[t]; i++) chk_v("dst byte", eq[i], dq[i]);
            chk_v("in count", exp_cnt(cn[t], cl[t]), dcnt);
            chk_v("in ch", 16'(cc[t]), 16'(dch));
            chk_v("dst ch", 16'(cc[t]), 16'(dsc));
            cnt_ch = 2'(cc[t]);
            repeat (2) @(negedge ref_clk);
            chk_v("count", exp_cnt(cn[t], cl[t]), cnt_val);
            for (int j = 0; j < 200 && far.got.size() < 2; j++) @(negedge ref_clk);
            tk(CPE_TK_HEADER, 8'(cc[t]));
            tk(CPE_TK_PACKET_END, 8'h00);
            chk_t("ack");
        end
        rx(8'h07, 0, CPE_TK_MESSAGE_END);
        till(ev + 1);
        chk_v("err kind", 16'(CPE_ERR_HEADER), 16'(ek));
        rx(8'h00, 3, CPE_TK_PACKET_END);
        till(ev + 1);
        chk_v("err kind", 16'(CPE_ERR_SHORT), 16'(ek));
        rx(8'h00, 33, CPE_TK_MESSAGE_END);
        till(ev + 1);
        chk_v("err kind", 16'(CPE_ERR_OVERSIZE), 16'(ek));
        hold = 1'b1;
        si = 0;
        req(1'b1, 2'h2, 16'h28);
        repeat (10) @(negedge ref_clk);
        rst = 1'b1;
        @(negedge ref_clk);
        chk_v("tx valid", 16'h0, 16'(tx_valid));
        rst = 1'b0;
        repeat (80) @(negedge ref_clk);
        chk_v("idle", 16'h0, 16'({tx_valid, src_req}));
        stop_test();
    end
endmodule : testbench
`default_nettype wire
